// ==== include/pfcu_pkg.sv ====
// Function
// - Call stores next address at the stack top, loads target, stack top advances by two.
// - Jump and call reach any program address; a jump leaves the stack alone.
// - Delay with the work register operand stalls work register value plus one cycles.
// - Delay with an immediate operand stalls constant plus one cycles.
// - Delay with a memory operand stalls data byte plus one cycles.
// - Delay cycles are counted on the executing thread's instruction clock.
// - Work register is the running delay count and ends at zero.
// - Return-with-value loads the immediate into the work register, then returns.
// - Return lowers the stack top by two, then reloads the program counter from it.
// - Interrupt return returns through the stack and sets the global interrupt enable.
// - Relative jump sets program counter to current value plus unsigned work register.
// - These instructions leave all flags alone; no-operation changes nothing.
// - Dedicated instructions set and clear the global interrupt enable.
// - With one thread, call and jump take two instruction cycles.
//
// Purpose: Shared constants and types of the program flow control unit.
// Assumes: 8-bit data path, program counter up to 16 bits.
// Notes:   Opcode codes are the decoder's internal encoding.
package pfcu_pkg;
  // ==========================================================
  // Widths and steps
  localparam int BYTE_W = 8;
  localparam int RET_W = 16;
  localparam logic [7:0] SP_STEP = 8'h02;
  localparam logic [7:0] SP_HI_OFS = 8'h01;
  localparam logic [7:0] DLY_LAST = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [RET_W-1:0] PC_INC = 16'h0001;
  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_GOTO = 4'h1,
    OP_CALL = 4'h2,
    OP_RET = 4'h3,
    OP_RET_IMM = 4'h4,
    OP_RETI = 4'h5,
    OP_DELAY_A = 4'h6,
    OP_DELAY_I = 4'h7,
    OP_DELAY_M = 4'h8,
    OP_PCADD = 4'h9,
    OP_GIE_ON = 4'ha,
    OP_GIE_OFF = 4'hb
  } pfcu_op_t;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CALL_HI = 3'h1,
    ST_JUMP_2 = 3'h2,
    ST_RET_HI = 3'h3,
    ST_RET_END = 3'h4,
    ST_DELAY = 3'h5
  } pfcu_state_t;
endpackage : pfcu_pkg

// ==== logic/pfcu_delay_counter.sv ====
// Purpose: Down counter that paces the delay instructions.
// Assumes: tick is the executing thread's instruction-cycle enable.
// Notes:   Holds its value between ticks.
`timescale 1ns/100ps
module pfcu_delay_counter
  import pfcu_pkg::*;
#(
  parameter int W = 8
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic [W-1:0] startValue,
  // Count
  output logic [W-1:0] count,
  output logic [W-1:0] countNext,
  output logic lastStep
);
  assign countNext = W'(count - DLY_LAST);
  assign lastStep = (count == W'(DLY_LAST));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      count <= '0;
    else if (start)
      count <= startValue;
    else if (tick && count != '0)
      count <= countNext;
  end
endmodule : pfcu_delay_counter

// ==== logic/pfcu_top.sv ====
// Purpose: Executes call, jump, returns, delays, no-operation, relative jump and interrupt enable.
// Assumes: One instruction offered per thread cycle; stack reads answer by the next tick.
// Notes:   The flag register is never touched, so it has no port here.
`timescale 1ns/100ps
module pfcu_top
  import pfcu_pkg::*;
#(
  parameter int PC_W = 12
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Thread timing
  input wire logic tick,
  input wire logic singleThread,
  // Instruction
  input wire logic instrValid,
  input wire logic [3:0] instrOp,
  input wire logic [7:0] instrImm,
  input wire logic [PC_W-1:0] instrTarget,
  input wire logic [7:0] memOperand,
  output logic busy,
  output logic instrDone,
  // Program counter
  input wire logic [PC_W-1:0] pcCur,
  output logic pcLoad,
  output logic [PC_W-1:0] pcNext,
  // Work register
  input wire logic [7:0] workRegIn,
  output logic workRegLoad,
  output logic [7:0] workRegNext,
  // Stack top pointer and data memory
  input wire logic [7:0] stackTopPointerIn,
  output logic spLoad,
  output logic [7:0] spNext,
  output logic memWe,
  output logic memRe,
  output logic [7:0] memAddr,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  // Global interrupt enable
  output logic gieSet,
  output logic gieClr
);
  // ==========================================================
  // Decode
  pfcu_state_t state;
  pfcu_state_t next_state;
  logic next_done;
  pfcu_op_t opT;
  logic take;
  logic isDelay;
  logic [7:0] dlyStart;
  logic [7:0] dlyCount;
  logic [7:0] dlyCountNext;
  logic dlyLast;
  logic retiPend;
  logic [PC_W-1:0] heldTarget;
  logic [7:0] spBase;
  logic [7:0] retHigh;
  logic [7:0] retLo;
  logic [RET_W-1:0] retAddr;

  assign opT = pfcu_op_t'(instrOp);
  assign take = instrValid && tick && state == ST_IDLE;
  assign isDelay = opT == OP_DELAY_A || opT == OP_DELAY_I || opT == OP_DELAY_M;
  assign retAddr = RET_W'(pcCur) + PC_INC;

  always_comb
  begin
    unique case (opT)
      OP_DELAY_A: dlyStart = workRegIn;
      OP_DELAY_I: dlyStart = instrImm;
      OP_DELAY_M: dlyStart = memOperand;
      default: dlyStart = BYTE_ZERO;
    endcase
  end

  pfcu_delay_counter #(.W(BYTE_W)) u_delay (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick(tick),
    .start(take && isDelay),
    .startValue(dlyStart),
    .count(dlyCount),
    .countNext(dlyCountNext),
    .lastStep(dlyLast)
  );

  // ==========================================================
  // Sequencer
  always_comb
  begin
    next_state = state;
    next_done = 1'b0;
    if (take)
    begin
      unique case (opT)
        OP_CALL: next_state = ST_CALL_HI;
        OP_GOTO:
          if (singleThread)
            next_state = ST_JUMP_2;
          else
            next_done = 1'b1;
        OP_RET, OP_RET_IMM, OP_RETI: next_state = ST_RET_HI;
        OP_DELAY_A, OP_DELAY_I, OP_DELAY_M:
          if (dlyStart == BYTE_ZERO)
            next_done = 1'b1;
          else
            next_state = ST_DELAY;
        default: next_done = 1'b1;
      endcase
    end
    else if (tick)
    begin
      unique case (state)
        ST_IDLE: next_state = ST_IDLE;
        ST_RET_HI: next_state = ST_RET_END;
        ST_DELAY:
          if (dlyLast)
          begin
            next_state = ST_IDLE;
            next_done = 1'b1;
          end
        default:
        begin
          next_state = ST_IDLE;
          next_done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      busy <= 1'b0;
      instrDone <= 1'b0;
      retiPend <= 1'b0;
      heldTarget <= '0;
    end
    else
    begin
      state <= next_state;
      busy <= next_state != ST_IDLE;
      instrDone <= next_done;
      if (take)
      begin
        retiPend <= opT == OP_RETI;
        heldTarget <= instrTarget;
      end
    end
  end

  // ==========================================================
  // Program counter
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pcLoad <= 1'b0;
      pcNext <= '0;
    end
    else
    begin
      pcLoad <= 1'b0;
      if (take && opT == OP_GOTO && !singleThread)
      begin
        pcLoad <= 1'b1;
        pcNext <= instrTarget;
      end
      else if (take && opT == OP_PCADD)
      begin
        pcLoad <= 1'b1;
        pcNext <= pcCur + PC_W'(workRegIn);
      end
      else if (tick && (state == ST_JUMP_2 || state == ST_CALL_HI))
      begin
        pcLoad <= 1'b1;
        pcNext <= heldTarget;
      end
      else if (tick && state == ST_RET_END)
      begin
        pcLoad <= 1'b1;
        pcNext <= PC_W'({memRdData, retLo});
      end
    end
  end

  // ==========================================================
  // Stack and data memory
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      spLoad <= 1'b0;
      spNext <= BYTE_ZERO;
      memWe <= 1'b0;
      memRe <= 1'b0;
      memAddr <= BYTE_ZERO;
      memWrData <= BYTE_ZERO;
      spBase <= BYTE_ZERO;
      retHigh <= BYTE_ZERO;
      retLo <= BYTE_ZERO;
    end
    else
    begin
      spLoad <= 1'b0;
      memWe <= 1'b0;
      memRe <= 1'b0;
      if (take && opT == OP_CALL)
      begin
        memWe <= 1'b1;
        memAddr <= stackTopPointerIn;
        memWrData <= retAddr[BYTE_W-1:0];
        retHigh <= retAddr[RET_W-1:BYTE_W];
        spBase <= stackTopPointerIn;
      end
      else if (take && (opT == OP_RET || opT == OP_RET_IMM || opT == OP_RETI))
      begin
        spLoad <= 1'b1;
        spNext <= stackTopPointerIn - SP_STEP;
        memRe <= 1'b1;
        memAddr <= stackTopPointerIn - SP_STEP;
        spBase <= stackTopPointerIn - SP_STEP;
      end
      else if (tick && state == ST_CALL_HI)
      begin
        memWe <= 1'b1;
        memAddr <= spBase + SP_HI_OFS;
        memWrData <= retHigh;
        spLoad <= 1'b1;
        spNext <= spBase + SP_STEP;
      end
      else if (tick && state == ST_RET_HI)
      begin
        retLo <= memRdData;
        memRe <= 1'b1;
        memAddr <= spBase + SP_HI_OFS;
      end
    end
  end

  // ==========================================================
  // Work register
  // Nothing else may write the work register during a delay, it is the counter.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      workRegLoad <= 1'b0;
      workRegNext <= BYTE_ZERO;
    end
    else
    begin
      workRegLoad <= 1'b0;
      if (take && opT == OP_RET_IMM)
      begin
        workRegLoad <= 1'b1;
        workRegNext <= instrImm;
      end
      else if (take && isDelay)
      begin
        workRegLoad <= 1'b1;
        workRegNext <= dlyStart;
      end
      else if (tick && state == ST_DELAY)
      begin
        workRegLoad <= 1'b1;
        workRegNext <= dlyCountNext;
      end
    end
  end

  // ==========================================================
  // Global interrupt enable
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      gieSet <= 1'b0;
      gieClr <= 1'b0;
    end
    else
    begin
      gieSet <= (take && opT == OP_GIE_ON) || (tick && state == ST_RET_END && retiPend);
      gieClr <= take && opT == OP_GIE_OFF;
    end
  end

  // ==========================================================
  // Checks
  logic [8:0] hTicks;
  logic [7:0] hReq;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hTicks <= '0;
      hReq <= BYTE_ZERO;
    end
    else if (take && isDelay)
    begin
      hTicks <= 9'h001;
      hReq <= dlyStart;
    end
    else if (tick && state == ST_DELAY)
      hTicks <= hTicks + 9'h001;
  end

  sequence s_take(pfcu_op_t o);
    take && opT == o;
  endsequence
  sequence s_step(pfcu_state_t s);
    tick && state == s;
  endsequence

  property p_call_lo;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_CALL) |=> memWe && memAddr == $past(stackTopPointerIn) && !pcLoad && busy;
  endproperty
  a_call_lo: assert property (p_call_lo) else $error("call low byte misplaced");
  property p_call_end;
    @(posedge sys_clk) disable iff (!rst_n)
    s_step(ST_CALL_HI) |=> pcLoad && spLoad && spNext == $past(spBase) + SP_STEP && instrDone;
  endproperty
  a_call_end: assert property (p_call_end) else $error("call end wrong");
  property p_goto;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_GOTO) ##0 !singleThread |=> pcLoad && pcNext == $past(instrTarget) && !spLoad && !memWe;
  endproperty
  a_goto: assert property (p_goto) else $error("jump wrong");
  property p_goto_two;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_GOTO) ##0 singleThread |=> !pcLoad && busy;
  endproperty
  a_goto_two: assert property (p_goto_two) else $error("single thread jump not two cycles");
  property p_delay_len;
    @(posedge sys_clk) disable iff (!rst_n)
    s_step(ST_DELAY) ##0 dlyLast |-> hTicks == {1'b0, hReq} ##1 workRegNext == BYTE_ZERO && instrDone;
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("delay length wrong");
  property p_delay_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    state == ST_DELAY && !tick |=> $stable(dlyCount) && !workRegLoad;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay moved without tick");
  property p_ret_sp;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_RET) |=> spLoad && spNext == $past(stackTopPointerIn) - SP_STEP && memRe && memAddr == spNext;
  endproperty
  a_ret_sp: assert property (p_ret_sp) else $error("return stack step wrong");
  property p_ret_imm;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_RET_IMM) |=> workRegLoad && workRegNext == $past(instrImm) && memRe;
  endproperty
  a_ret_imm: assert property (p_ret_imm) else $error("return value not loaded");
  property p_reti;
    @(posedge sys_clk) disable iff (!rst_n)
    s_step(ST_RET_END) ##0 retiPend |=> gieSet && pcLoad;
  endproperty
  a_reti: assert property (p_reti) else $error("interrupt return left enable off");
  property p_pcadd;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_PCADD) |=> pcLoad && pcNext == $past(pcCur) + PC_W'($past(workRegIn));
  endproperty
  a_pcadd: assert property (p_pcadd) else $error("relative jump wrong");
  property p_nop;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_NOP) |=> instrDone && !pcLoad && !spLoad && !memWe && !workRegLoad && !gieSet && !gieClr;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");
  property p_gie_off;
    @(posedge sys_clk) disable iff (!rst_n)
    s_take(OP_GIE_OFF) |=> gieClr && !gieSet;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("enable not cleared");
endmodule : pfcu_top

// ==== bench/pfcu_top_test.sv ====
// Purpose: Self-checking bench of the program flow control unit.
// Assumes: Thread tick every second sys_clk; bench models pc, stack top, work register, memory.
// Notes:   Pulse counts per instruction are kept modulo 16.
`timescale 1ns/100ps
module pfcu_top_test
  import pfcu_pkg::*;
;
  localparam int PW = 12;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic singleThread = 1'b0;
  logic instrValid = 1'b0;
  logic [3:0] instrOp = 4'h0;
  logic [7:0] instrImm = 8'h00;
  logic [PW-1:0] instrTarget = 12'h000;
  logic [7:0] memOperand = 8'h00;
  logic [PW-1:0] pcCur = 12'h000;
  logic [7:0] workRegIn = 8'h00;
  logic [7:0] stackTopPointerIn = 8'h00;
  logic [7:0] memRdData = 8'h00;
  logic busy, instrDone, pcLoad, workRegLoad, spLoad, memWe, memRe, gieSet, gieClr;
  logic [PW-1:0] pcNext;
  logic [7:0] workRegNext, spNext, memAddr, memWrData;
  logic [6:0] pulses;
  logic [7:0] mem [256];
  int c [7] = '{0, 0, 0, 0, 0, 0, 0};
  int err_count = 0;
  int checked = 0;

  pfcu_top #(.PC_W(PW)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(tick), .singleThread(singleThread),
    .instrValid(instrValid), .instrOp(instrOp), .instrImm(instrImm), .instrTarget(instrTarget),
    .memOperand(memOperand), .busy(busy), .instrDone(instrDone), .pcCur(pcCur),
    .pcLoad(pcLoad), .pcNext(pcNext), .workRegIn(workRegIn), .workRegLoad(workRegLoad),
    .workRegNext(workRegNext), .stackTopPointerIn(stackTopPointerIn), .spLoad(spLoad),
    .spNext(spNext), .memWe(memWe), .memRe(memRe), .memAddr(memAddr), .memWrData(memWrData),
    .memRdData(memRdData), .gieSet(gieSet), .gieClr(gieClr)
  );

  // ==========================================================
  // Clock, thread tick and surroundings
  always #5 sys_clk = ~sys_clk;
  // Thread runs at half the system rate, so sys_clk counting shows up
  always @(posedge sys_clk)
    tick <= ~tick;
  assign pulses = {gieClr, gieSet, workRegLoad, pcLoad, spLoad, memRe, memWe};
  always @(posedge sys_clk)
  begin
    if (pcLoad)
      pcCur <= pcNext;
    if (spLoad)
      stackTopPointerIn <= spNext;
    if (workRegLoad)
      workRegIn <= workRegNext;
    if (memWe)
      mem[memAddr] <= memWrData;
    // Stale read data is inverted so a late sample cannot pass by luck
    if (memRe)
      memRdData <= mem[memAddr];
    else
      memRdData <= ~memRdData;
    foreach (c[i])
      c[i] += pulses[i];
  end

  // ==========================================================
  // Shared tasks
  // Wide enough for a cycle count joined to the 28-bit pulse tally, so nothing is cut off
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic setup(input logic [PW-1:0] pc, input logic [7:0] sp, input logic [7:0] wr);
    @(posedge sys_clk);
    pcCur <= pc;
    stackTopPointerIn <= sp;
    workRegIn <= wr;
  endtask : setup

  // Offers one instruction, counts thread cycles up to its end and the pulses it gave
  task automatic exec(input logic [3:0] op, input logic [7:0] imm, input logic [PW-1:0] tgt,
                      input logic [7:0] mop, output int cyc, output logic [27:0] d);
    int b [7];
    int guard;
    b = c;
    guard = 0;
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrOp <= op;
    instrImm <= imm;
    instrTarget <= tgt;
    memOperand <= mop;
    do
    begin
      @(posedge sys_clk);
      guard++;
    end
    while (!(tick === 1'b1 && busy === 1'b0) && guard < 50);
    instrValid <= 1'b0;
    cyc = 1;
    #1;
    while (instrDone !== 1'b1 && guard < 1000)
    begin
      @(posedge sys_clk);
      if (tick === 1'b1)
        cyc++;
      guard++;
      #1;
    end
    @(posedge sys_clk);
    #1;
    foreach (b[i])
      d[27-4*i -: 4] = 4'(c[i] - b[i]);
  endtask : exec

  // ==========================================================
  // Scenarios
  task automatic t_nop_goto();
    int cyc;
    logic [27:0] d;
    setup(12'h123, 8'h20, 8'h5a);
    exec(OP_NOP, 8'h77, 12'h456, 8'h00, cyc, d);
    check(cyc, 1, "nop cycles");
    check({d, pcCur}, {28'h0, 12'h123}, "nop changes");
    exec(4'hf, 8'h77, 12'h456, 8'h00, cyc, d);
    check({d, pcCur}, {28'h0, 12'h123}, "unused code changes");
    exec(OP_GOTO, 8'h00, 12'hfff, 8'h00, cyc, d);
    check(d, 28'h0001000, "goto pulses");
    check({pcCur, stackTopPointerIn}, {12'hfff, 8'h20}, "goto pc and sp");
    @(posedge sys_clk);
    singleThread <= 1'b1;
    exec(OP_GOTO, 8'h00, 12'h000, 8'h00, cyc, d);
    check(cyc, 2, "single-thread goto cycles");
    check(pcCur, 12'h000, "single-thread goto pc");
    exec(OP_NOP, 8'h00, 12'h000, 8'h00, cyc, d);
    check(cyc, 1, "single-thread nop cycles");
    @(posedge sys_clk);
    singleThread <= 1'b0;
  endtask : t_nop_goto

  task automatic t_call_ret();
    int cyc;
    logic [27:0] d;
    setup(12'h1fe, 8'h10, 8'h33);
    exec(OP_CALL, 8'h00, 12'h800, 8'h00, cyc, d);
    check(cyc, 2, "call cycles");
    check(d, 28'h2011000, "call pulses");
    check({pcCur, stackTopPointerIn}, {12'h800, 8'h12}, "call pc and sp");
    check({mem[8'h11], mem[8'h10]}, 16'h01ff, "return address bytes");
    exec(OP_CALL, 8'h00, 12'h3c0, 8'h00, cyc, d);
    check({mem[8'h13], mem[8'h12], stackTopPointerIn}, 24'h080114, "nested call");
    exec(OP_RET_IMM, 8'h55, 12'h000, 8'h00, cyc, d);
    check(d, 28'h0211100, "return-with-value pulses");
    check(workRegIn, 8'h55, "return value");
    check({pcCur, stackTopPointerIn}, {12'h801, 8'h12}, "return-with-value pc and sp");
    exec(OP_RETI, 8'h00, 12'h000, 8'h00, cyc, d);
    check(d, 28'h0211010, "interrupt return pulses");
    check({pcCur, stackTopPointerIn}, {12'h1ff, 8'h10}, "interrupt return pc and sp");
    exec(OP_CALL, 8'h00, 12'h0ab, 8'h00, cyc, d);
    check({mem[8'h11], mem[8'h10]}, 16'h0200, "carried return address");
    exec(OP_RET, 8'h00, 12'h000, 8'h00, cyc, d);
    check({cyc, d}, {32'd3, 28'h0211000}, "return cycles and pulses");
    check({pcCur, stackTopPointerIn}, {12'h200, 8'h10}, "return pc and sp");
    check(workRegIn, 8'h55, "work register kept by calls");
  endtask : t_call_ret

  task automatic one_delay(input logic [3:0] op, input logic [7:0] n);
    int cyc;
    logic [27:0] d;
    // Operands of the other forms carry decoys; nothing touches the work register meanwhile
    setup(12'h040, 8'h20, (op == OP_DELAY_A) ? n : 8'ha5);
    exec(op, (op == OP_DELAY_I) ? n : 8'h3c, 12'h000, (op == OP_DELAY_M) ? n : 8'hc3, cyc, d);
    check(cyc, n + 1, "delay thread cycles");
    check(workRegIn, 8'h00, "work register after delay");
    check(d, {16'h0, 4'(n + 8'h01), 8'h00}, "delay pulses");
    check(pcCur, 12'h040, "delay keeps pc");
  endtask : one_delay

  task automatic t_pcadd_gie();
    int cyc;
    logic [27:0] d;
    setup(12'h100, 8'h20, 8'h02);
    exec(OP_PCADD, 8'h00, 12'h000, 8'h00, cyc, d);
    check({d, pcCur}, {28'h0001000, 12'h102}, "relative jump by two");
    check(workRegIn, 8'h02, "relative jump keeps work register");
    setup(12'h0f0, 8'h20, 8'hff);
    exec(OP_PCADD, 8'h00, 12'h000, 8'h00, cyc, d);
    check(pcCur, 12'h1ef, "relative jump unsigned");
    exec(OP_GIE_ON, 8'h00, 12'h000, 8'h00, cyc, d);
    check({cyc, d}, {32'd1, 28'h0000010}, "enable interrupts");
    exec(OP_GIE_OFF, 8'h00, 12'h000, 8'h00, cyc, d);
    check({cyc, d}, {32'd1, 28'h0000001}, "disable interrupts");
  endtask : t_pcadd_gie

  // ==========================================================
  // Sequence and verdict
  task automatic report_and_stop();
    $display("Checks: %0d, mismatches: %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    @(posedge sys_clk);
    #1;
    check({busy, instrDone, pulses}, 32'h0, "outputs in reset");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    t_nop_goto();
    t_call_ret();
    one_delay(OP_DELAY_I, 8'h05);
    one_delay(OP_DELAY_I, 8'h00);
    one_delay(OP_DELAY_A, 8'h0f);
    one_delay(OP_DELAY_A, 8'h01);
    one_delay(OP_DELAY_M, 8'hff);
    t_pcadd_gie();
    report_and_stop();
  end

  // Whole run needs under 2000 cycles; the limit leaves a wide margin
  initial
  begin
    #100000;
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : pfcu_top_test
